// ==== verilog/mfr_pkg.sv ====
// shared constants and types for the multi-wire fast read front end
package mfr_pkg;
  // opcodes of the supported multi-wire reads
  localparam logic [7:0] OP_DUAL_OUT4 = 8'h3c;  // dual output, 32-bit address
  localparam logic [7:0] OP_DUAL_IO   = 8'hbb;  // dual i/o, mode address
  localparam logic [7:0] OP_DUAL_IO4  = 8'hbc;  // dual i/o, 32-bit address
  localparam logic [7:0] OP_QUAD_OUT  = 8'h6b;  // quad output, mode address
  localparam logic [7:0] OP_QUAD_OUT4 = 8'h6c;  // quad output, 32-bit address
  localparam logic [7:0] OP_QUAD_IO   = 8'heb;  // quad i/o, mode address
  // dummy clock counts
  localparam logic [3:0] DUMMY_OUT    = 4'h8;   // dual and quad output reads
  localparam logic [3:0] DUMMY_QIO    = 4'h6;   // quad i/o read
  localparam logic [3:0] DUMMY_DIO    = 4'h4;   // dual i/o read, agreed by both ends
  // address widths in bits
  localparam logic [5:0] ADDR_BITS3   = 6'h18;  // 3-byte mode
  localparam logic [5:0] ADDR_BITS4   = 6'h20;  // 4-byte mode
  // host link clock divider: half period in system clocks
  localparam logic [3:0] SCK_HALF     = 4'h6;   // 48 ns link period at 4 ns
  // lanes per clock
  typedef enum logic [1:0] {W1, W2, W4} mfr_width_t;
  // phases of a command
  typedef enum logic [2:0] {PH_IDLE, PH_OPC, PH_ADDR, PH_DUMMY, PH_DATA, PH_REJ}
    mfr_phase_t;
endpackage

// ==== verilog/mfr_link_if.sv ====
// link wires between the host controller and the flash front end
interface mfr_link_if;
  logic       csB;      // chip select, active low, host driven
  logic       sck;      // serial clock, host driven
  logic [3:0] hostOut;  // host drive value per io line
  logic [3:0] hostOe;   // host drive enable per io line
  logic [3:0] devOut;   // device drive value per io line
  logic [3:0] devOe;    // device drive enable per io line
  logic [3:0] ioLine;   // resolved io_line_3..io_line_0 level
  // resolve each line: drivers win, undriven lines pull high
  for (genvar i = 0; i < 4; i++) begin : g_res
    assign ioLine[i] = hostOe[i] ? hostOut[i] : (devOe[i] ? devOut[i] : 1'b1);
  end
  modport host (output csB, output sck, output hostOut, output hostOe, input ioLine);
  modport dev  (input csB, input sck, output devOut, output devOe, input ioLine);
endinterface

// ==== verilog/mfr_flash_end.sv ====
// flash-side front end: decodes multi-wire fast reads and streams array data
// Function
// - 3Ch returns data on two lines
// - 3Ch: 32-bit serial address, eight dummies
// - dummy inputs ignored; host releases before data
// - BBh address two bits per clock, mode width
// - BCh address always 32 bits, two-wide
// - dual i/o: opcode serial, rest two-wide
// - sample on rising, drive on falling edge
// - address increments per byte, wraps to zero
// - host sets extended address before high reads; host end has none, 3-byte reads send addr[23:0]
// - 6Bh serial address, eight dummies, quad data
// - 6Ch 32-bit serial address, eight dummies
// - host drives io 2,3 high when enabled
// - EBh quad address, six dummies, quad data
// - quad i/o: opcode serial, rest four-wide
// - chip select high ends read anytime
// - address-mode state chooses 3 or 4 bytes
// - reads rejected while array cycle busy
module mfr_flash_end (
  input  wire logic        clk,        // system clock
  input  wire logic        rst_b,      // async reset, active low
  mfr_link_if.dev          link,       // serial link
  input  wire logic        addrMode4,  // address-mode state: 1 = 4-byte
  input  wire logic        arrayBusy,  // program/erase/write cycle running
  input  wire logic [7:0]  rdData,     // array byte at rdAddr
  output logic      [31:0] rdAddr,     // array read address
  output logic             rdStrobe,   // pulse: byte consumed, address moves
  output logic             rejected    // pulse: read refused while busy
);
  typedef struct packed {
    logic [1:0]  csSync;    // chip select synchroniser
    logic [1:0]  sckSync;   // clock synchroniser
    logic        sckPrev;   // last synchronised clock
    logic [3:0]  io0;       // io synchroniser stage one
    logic [3:0]  io1;       // io synchroniser stage two
    mfr_pkg::mfr_phase_t phase;  // command phase
    mfr_pkg::mfr_width_t width;  // lanes of addr/data
    mfr_pkg::mfr_width_t dWidth; // lanes of data
    logic [7:0]  opc;       // opcode shift
    logic [5:0]  cnt;       // bits left in phase
    logic [3:0]  dummy;     // dummy clocks for command
    logic [31:0] addr;      // read address
    logic [7:0]  shreg;     // output byte shift
    logic [3:0]  left;      // bits left in byte
    logic [3:0]  dOut;      // driven levels
    logic [3:0]  dOe;       // drive enables
    logic        strobe;    // byte consumed pulse
    logic        rej;       // rejection pulse
  } mfr_dev_st_t;
  // registered state and the value it takes at the next edge
  mfr_dev_st_t s_r, s_nxt;
  logic csHi, rise, fall;   // decoded link events
  logic [2:0] step;         // bits per clock
  logic [7:0] op;           // completed opcode
  logic [7:0] outByte;      // byte being shifted out
  // link events come only from the second synchroniser stage, never the raw pins
  assign csHi = s_r.csSync[1];
  assign rise = s_r.sckSync[1] & ~s_r.sckPrev;
  assign fall = ~s_r.sckSync[1] & s_r.sckPrev;
  // lanes carried per clock in the current phase
  always_comb begin
    case (s_r.width)
      mfr_pkg::W2: step = 3'h2;
      mfr_pkg::W4: step = 3'h4;
      default:     step = 3'h1;
    endcase
  end
  // opcode including the bit sampled at this rise
  assign op = {s_r.opc[6:0], s_r.io1[0]};
  // a fresh array byte once the last one is spent, else the rest of the current one
  assign outByte = (s_r.left == 4'h0) ? rdData : s_r.shreg;
  // next state: sample on rising edges, drive on falling edges
  always_comb begin
    s_nxt = s_r;
    s_nxt.csSync  = {s_r.csSync[0], link.csB};
    s_nxt.sckSync = {s_r.sckSync[0], link.sck};
    s_nxt.sckPrev = s_r.sckSync[1];
    s_nxt.io0     = link.ioLine;
    s_nxt.io1     = s_r.io0;
    s_nxt.strobe  = 1'b0;
    s_nxt.rej     = 1'b0;
    if (csHi) begin
      // deselect: release lines and wait for a new opcode
      s_nxt.phase = mfr_pkg::PH_IDLE;
      s_nxt.dOe   = 4'h0;
    end else begin
      case (s_r.phase)
        mfr_pkg::PH_IDLE: begin
          s_nxt.phase = mfr_pkg::PH_OPC;
          s_nxt.cnt   = 6'h08;
          s_nxt.width = mfr_pkg::W1;
        end
        mfr_pkg::PH_OPC: if (rise) begin
          s_nxt.opc = op;
          s_nxt.cnt = s_r.cnt - 6'h01;
          if (s_r.cnt == 6'h01) begin
            s_nxt.phase = mfr_pkg::PH_ADDR;
            s_nxt.addr  = 32'h0;
            // mode state sets the width unless opcode fixes it
            s_nxt.cnt   = addrMode4 ? mfr_pkg::ADDR_BITS4 : mfr_pkg::ADDR_BITS3;
            s_nxt.dummy = mfr_pkg::DUMMY_OUT;
            case (op)
              mfr_pkg::OP_DUAL_OUT4: begin
                s_nxt.cnt = mfr_pkg::ADDR_BITS4;
                s_nxt.dWidth = mfr_pkg::W2;
              end
              mfr_pkg::OP_DUAL_IO: begin
                s_nxt.width = mfr_pkg::W2;
                s_nxt.dWidth = mfr_pkg::W2;
                s_nxt.dummy = mfr_pkg::DUMMY_DIO;
              end
              mfr_pkg::OP_DUAL_IO4: begin
                s_nxt.cnt = mfr_pkg::ADDR_BITS4;
                s_nxt.width = mfr_pkg::W2;
                s_nxt.dWidth = mfr_pkg::W2;
                s_nxt.dummy = mfr_pkg::DUMMY_DIO;
              end
              mfr_pkg::OP_QUAD_OUT: s_nxt.dWidth = mfr_pkg::W4;
              mfr_pkg::OP_QUAD_OUT4: begin
                s_nxt.cnt = mfr_pkg::ADDR_BITS4;
                s_nxt.dWidth = mfr_pkg::W4;
              end
              mfr_pkg::OP_QUAD_IO: begin
                s_nxt.width = mfr_pkg::W4;
                s_nxt.dWidth = mfr_pkg::W4;
                s_nxt.dummy = mfr_pkg::DUMMY_QIO;
              end
              default: s_nxt.phase = mfr_pkg::PH_REJ;  // unsupported: stay quiet
            endcase
            if (arrayBusy) begin
              s_nxt.phase = mfr_pkg::PH_REJ;
              s_nxt.rej   = 1'b1;
            end
          end
        end
        mfr_pkg::PH_ADDR: if (rise) begin
          case (s_r.width)
            mfr_pkg::W2: s_nxt.addr = {s_r.addr[29:0], s_r.io1[1:0]};
            mfr_pkg::W4: s_nxt.addr = {s_r.addr[27:0], s_r.io1};
            default:     s_nxt.addr = {s_r.addr[30:0], s_r.io1[0]};
          endcase
          s_nxt.cnt = s_r.cnt - {3'h0, step};
          if (s_r.cnt == {3'h0, step}) begin
            s_nxt.phase = mfr_pkg::PH_DUMMY;
            s_nxt.cnt   = {2'h0, s_r.dummy};
          end
        end
        mfr_pkg::PH_DUMMY: if (rise) begin  // inputs are not looked at
          s_nxt.cnt = s_r.cnt - 6'h01;
          if (s_r.cnt == 6'h01) begin
            s_nxt.phase = mfr_pkg::PH_DATA;
            s_nxt.width = s_r.dWidth;
            s_nxt.left  = 4'h0;
          end
        end
        mfr_pkg::PH_DATA: if (fall) begin
          // drive on the fall; bits reach the lines three clocks after it, three clocks before the host's rise
          case (s_r.width)
            mfr_pkg::W2: begin
              s_nxt.dOut  = {2'h0, outByte[7:6]};
              s_nxt.dOe   = 4'h3;
              s_nxt.shreg = {outByte[5:0], 2'h0};
            end
            mfr_pkg::W4: begin
              s_nxt.dOut  = outByte[7:4];
              s_nxt.dOe   = 4'hf;
              s_nxt.shreg = {outByte[3:0], 4'h0};
            end
            default: begin
              s_nxt.dOut  = {2'h0, outByte[7], 1'b0};
              s_nxt.dOe   = 4'h2;
              s_nxt.shreg = {outByte[6:0], 1'b0};
            end
          endcase
          if (s_r.left == 4'h0) begin
            // byte taken: advance address, natural wrap to zero
            s_nxt.addr   = s_r.addr + 32'h1;
            s_nxt.strobe = 1'b1;
            s_nxt.left   = 4'h8 - {1'b0, step};
          end else begin
            s_nxt.left = s_r.left - {1'b0, step};
          end
        end
        // refused or unknown command: lines stay released, a host clocking on reads pull-ups
        mfr_pkg::PH_REJ: s_nxt.dOe = 4'h0;  // ignore the rest until deselect
        default: s_nxt.phase = mfr_pkg::PH_IDLE;
      endcase
    end
  end
  // one register for all state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
      // synchroniser starts deselected so no false frame follows reset
      s_r.csSync <= 2'h3;
      s_r.sckSync <= 2'h0;
    end else begin
      s_r <= s_nxt;
    end
  end
  // every output comes straight from the state register
  assign link.devOut = s_r.dOut;
  assign link.devOe  = s_r.dOe;
  assign rdAddr      = s_r.addr;
  assign rdStrobe    = s_r.strobe;
  assign rejected    = s_r.rej;
endmodule // mfr_flash_end

// ==== verilog/mfr_host_end.sv ====
// host-side controller: issues one multi-wire fast read and collects bytes
module mfr_host_end (
  input  wire logic        clk,       // system clock
  input  wire logic        rst_b,     // async reset, active low
  mfr_link_if.host         link,      // serial link
  input  wire logic        start,     // pulse: begin a read
  input  wire logic [7:0]  opcode,    // one of the six read opcodes
  input  wire logic [31:0] addr,      // start address, msb first
  input  wire logic        addrMode4, // matches device address mode
  input  wire logic        stop,      // pulse: end the read
  input  wire logic        wpHold,    // pin functions enabled: drive 2,3 high
  output logic      [7:0]  rxData,    // collected byte
  output logic             rxValid,   // pulse: byte ready
  output logic             busy       // read in progress
);
  typedef struct packed {
    mfr_pkg::mfr_phase_t phase;  // command phase
    mfr_pkg::mfr_width_t aw;     // address lanes
    mfr_pkg::mfr_width_t dw;     // data lanes
    logic [3:0]  div;       // clock divider
    logic        sck;       // link clock
    logic        cs;        // chip select level
    logic [7:0]  opc;       // opcode shift
    logic [31:0] a;         // address shift
    logic [5:0]  cnt;       // bits left
    logic [3:0]  dummy;     // dummies of command
    logic [3:0]  out;       // drive values
    logic [3:0]  oe;        // drive enables
    logic [3:0]  io0;       // io sync stage one
    logic [3:0]  io1;       // io sync stage two
    logic [7:0]  rx;        // receive shift
    logic [3:0]  got;       // bits in rx
    logic [7:0]  data;      // completed byte
    logic        valid;     // byte pulse
  } mfr_host_st_t;
  mfr_host_st_t s_r, s_nxt;
  logic [2:0] aStep, dStep;  // lanes per clock
  always_comb begin
    aStep = (s_r.aw == mfr_pkg::W4) ? 3'h4 : (s_r.aw == mfr_pkg::W2) ? 3'h2 : 3'h1;
    dStep = (s_r.dw == mfr_pkg::W4) ? 3'h4 : (s_r.dw == mfr_pkg::W2) ? 3'h2 : 3'h1;
  end
  // next state: host changes outputs on falling, samples data on rising
  always_comb begin
    s_nxt = s_r;
    s_nxt.io0 = link.ioLine;
    s_nxt.io1 = s_r.io0;
    s_nxt.valid = 1'b0;
    if (s_r.phase == mfr_pkg::PH_IDLE) begin
      s_nxt.cs = 1'b1;
      s_nxt.sck = 1'b0;
      s_nxt.oe = 4'h0;
      if (start) begin
        s_nxt.phase = mfr_pkg::PH_OPC;
        s_nxt.cs = 1'b0;
        s_nxt.opc = opcode;
        s_nxt.cnt = 6'h08;
        s_nxt.div = 4'h0;
        s_nxt.aw = mfr_pkg::W1;
        s_nxt.dw = mfr_pkg::W1;
        s_nxt.dummy = mfr_pkg::DUMMY_OUT;
        s_nxt.out = {wpHold, wpHold, 1'b0, opcode[7]};
        s_nxt.oe = {wpHold, wpHold, 2'h1};
        s_nxt.a = addrMode4 ? addr : {addr[23:0], 8'h0};
        case (opcode)
          mfr_pkg::OP_DUAL_OUT4: s_nxt.dw = mfr_pkg::W2;
          mfr_pkg::OP_DUAL_IO: begin
            s_nxt.aw = mfr_pkg::W2;
            s_nxt.dw = mfr_pkg::W2;
            s_nxt.dummy = mfr_pkg::DUMMY_DIO;
          end
          mfr_pkg::OP_DUAL_IO4: begin
            s_nxt.aw = mfr_pkg::W2;
            s_nxt.dw = mfr_pkg::W2;
            s_nxt.dummy = mfr_pkg::DUMMY_DIO;
          end
          mfr_pkg::OP_QUAD_OUT, mfr_pkg::OP_QUAD_OUT4: s_nxt.dw = mfr_pkg::W4;
          mfr_pkg::OP_QUAD_IO: begin
            s_nxt.aw = mfr_pkg::W4;
            s_nxt.dw = mfr_pkg::W4;
            s_nxt.dummy = mfr_pkg::DUMMY_QIO;
          end
          default: s_nxt.aw = mfr_pkg::W1;
        endcase
        // fixed-width opcodes always send 32 bits
        if (opcode == mfr_pkg::OP_DUAL_OUT4 || opcode == mfr_pkg::OP_DUAL_IO4 ||
            opcode == mfr_pkg::OP_QUAD_OUT4) s_nxt.a = addr;
      end
    end else if (stop) begin
      s_nxt.phase = mfr_pkg::PH_IDLE;
      s_nxt.cs = 1'b1;
      s_nxt.oe = 4'h0;
      s_nxt.sck = 1'b0;
    end else if (s_r.div == mfr_pkg::SCK_HALF - 4'h1) begin
      s_nxt.div = 4'h0;
      s_nxt.sck = ~s_r.sck;
      if (!s_r.sck) begin
        // rising edge: collect data bits seen on the lines
        if (s_r.phase == mfr_pkg::PH_DATA) begin
          case (s_r.dw)
            mfr_pkg::W4: s_nxt.rx = {s_r.rx[3:0], s_r.io1};
            mfr_pkg::W2: s_nxt.rx = {s_r.rx[5:0], s_r.io1[1:0]};
            default:     s_nxt.rx = {s_r.rx[6:0], s_r.io1[1]};
          endcase
          if (s_r.got + {1'b0, dStep} == 4'h8) begin
            s_nxt.got = 4'h0;
            s_nxt.data = (s_r.dw == mfr_pkg::W4) ? {s_r.rx[3:0], s_r.io1} :
                         (s_r.dw == mfr_pkg::W2) ? {s_r.rx[5:0], s_r.io1[1:0]} :
                         {s_r.rx[6:0], s_r.io1[1]};
            s_nxt.valid = 1'b1;
          end else s_nxt.got = s_r.got + {1'b0, dStep};
        end
      end else begin
        // falling edge: present the next bits
        case (s_r.phase)
          mfr_pkg::PH_OPC: begin
            s_nxt.opc = {s_r.opc[6:0], 1'b0};
            s_nxt.cnt = s_r.cnt - 6'h01;
            s_nxt.out[0] = s_r.opc[6];
            if (s_r.cnt == 6'h01) begin
              s_nxt.phase = mfr_pkg::PH_ADDR;
              s_nxt.cnt = (addrMode4 || opcode == mfr_pkg::OP_DUAL_OUT4 ||
                          opcode == mfr_pkg::OP_DUAL_IO4 || opcode == mfr_pkg::OP_QUAD_OUT4)
                          ? mfr_pkg::ADDR_BITS4 : mfr_pkg::ADDR_BITS3;
              s_nxt.oe[3:0] = (s_r.aw == mfr_pkg::W4) ? 4'hf :
                              (s_r.aw == mfr_pkg::W2) ? {s_r.oe[3:2], 2'h3} : s_r.oe;
              case (s_r.aw)
                mfr_pkg::W4: s_nxt.out = s_r.a[31:28];
                mfr_pkg::W2: s_nxt.out = {s_r.out[3:2], s_r.a[31:30]};
                default:     s_nxt.out = {s_r.out[3:1], s_r.a[31]};
              endcase
            end
          end
          mfr_pkg::PH_ADDR: begin
            s_nxt.a = s_r.a << aStep;
            s_nxt.cnt = s_r.cnt - {3'h0, aStep};
            case (s_r.aw)
              mfr_pkg::W4: s_nxt.out = s_r.a[27:24];
              mfr_pkg::W2: s_nxt.out = {s_r.out[3:2], s_r.a[29:28]};
              default:     s_nxt.out = {s_r.out[3:1], s_r.a[30]};
            endcase
            if (s_r.cnt == {3'h0, aStep}) begin
              s_nxt.phase = mfr_pkg::PH_DUMMY;
              s_nxt.cnt = {2'h0, s_r.dummy};
              s_nxt.oe = 4'h0;
            end
          end
          mfr_pkg::PH_DUMMY: begin
            s_nxt.cnt = s_r.cnt - 6'h01;
            if (s_r.cnt == 6'h01) begin
              s_nxt.phase = mfr_pkg::PH_DATA;
              s_nxt.got = 4'h0;
            end
          end
          default: s_nxt.oe = 4'h0;
        endcase
      end
    end else s_nxt.div = s_r.div + 4'h1;
  end
  // one register for all state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
      s_r.cs <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign link.csB    = s_r.cs;
  assign link.sck    = s_r.sck;
  assign link.hostOut = s_r.out;
  assign link.hostOe = s_r.oe;
  assign rxData      = s_r.data;
  assign rxValid     = s_r.valid;
  assign busy        = ~s_r.cs;
endmodule // mfr_host_end

// ==== testbench/mfr_link_props.sv ====
// concurrent checks on the serial link between host controller and flash front end
module mfr_link_props (
  input wire logic       clk,    // system clock
  input wire logic       rst_b,  // async reset, active low
  input wire logic       csB,    // chip select, active low
  input wire logic       sck,    // serial clock
  input wire logic [3:0] hostOe, // host drive enables
  input wire logic [3:0] devOut, // device drive values
  input wire logic [3:0] devOe   // device drive enables
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] riseCnt_r; // serial clock rises seen in this frame
  logic       sckQ_r;    // serial clock one cycle ago

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // count rises per frame; saturates so a long data stream cannot wrap it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      riseCnt_r <= 6'h00;
      sckQ_r    <= 1'b0;
    end else begin
      sckQ_r <= sck;
      if (csB) begin
        riseCnt_r <= 6'h00; // frame over
      end else if (sck && !sckQ_r && riseCnt_r != 6'h3f) begin
        riseCnt_r <= riseCnt_r + 6'h01;
      end
    end
  end

  a_no_line_fight: assert property ((hostOe & devOe) == 4'h0)
    else $error("host and device drive one line together");
  a_quiet_when_idle: assert property (csB [*5] |-> devOe == 4'h0)
    else $error("device still drives after chip select went high");
  a_drive_on_fall: assert property (!csB && $past(devOe) != 4'h0 && $changed(devOut)
    |-> !sck)
    else $error("device data changed while serial clock high");
  a_hold_at_rise: assert property ($rose(sck) && devOe != 4'h0
    |-> $stable(devOut) ##1 $stable(devOut))
    else $error("device data moved around a rising edge");
  a_low_half_len: assert property ($fell(sck) |-> (!sck) [*6])
    else $error("serial clock low half shorter than six cycles");
  a_frame_starts_low: assert property ($fell(csB) |-> !sck)
    else $error("frame opened with serial clock high");
  a_lane_set: assert property (devOe == 4'h0 || devOe == 4'h3 || devOe == 4'hf)
    else $error("device enables an odd lane set");
  a_prefix_silent: assert property (!csB && riseCnt_r < 6'd20 |-> devOe == 4'h0)
    else $error("device drove before shortest command prefix ended");
  a_opcode_serial: assert property (!csB && riseCnt_r > 6'd0 && riseCnt_r < 6'd8
    |-> hostOe[0] && !hostOe[1])
    else $error("opcode not sent on line zero alone");
endmodule // mfr_link_props

// ==== testbench/multi_io_fast_read_front_end_tb_top.sv ====
// self-checking bench: host end and flash end joined across the link
module multi_io_fast_read_front_end_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;       // system clock
  logic        rst_b;     // reset, active low
  logic        start;     // host read request pulse
  logic [7:0]  opcode;    // read opcode
  logic [31:0] addr;      // start address
  logic        mode4;     // address-mode state, both ends
  logic        stop;      // host end-of-read pulse
  logic        wpHold;    // pin functions enabled
  logic        arrayBusy; // array cycle running
  logic [7:0]  rdData;    // array byte model
  logic [31:0] rdAddr;    // array read address
  logic        rdStrobe;  // byte taken
  logic        rejected;  // read refused
  logic [7:0]  rxData;    // collected byte
  logic        rxValid;   // byte ready
  logic        busy;      // host frame open
  int          errors;    // mismatch count
  int          checks;    // comparison count
  logic        sckQ;      // serial clock one cycle ago
  logic [5:0]  rises;     // rises in current frame
  logic [5:0]  dataRise;  // rises seen when device first drove
  logic [3:0]  dataOe;    // lanes device first enabled
  int          rejCnt;    // refusal pulses seen
  int          strobeCnt; // bytes taken by the device

  mfr_link_if lnk ();

  // array content: every address byte folds in so a wrong width shows
  function automatic logic [7:0] dataOf(input logic [31:0] a);
    return a[31:24] ^ a[23:16] ^ a[15:8] ^ a[7:0] ^ 8'h5a;
  endfunction
  assign rdData = dataOf(rdAddr);

  mfr_host_end u_mfr_host_end (.clk(clk), .rst_b(rst_b), .link(lnk), .start(start),
    .opcode(opcode), .addr(addr), .addrMode4(mode4), .stop(stop), .wpHold(wpHold),
    .rxData(rxData), .rxValid(rxValid), .busy(busy));
  mfr_flash_end u_mfr_flash_end (.clk(clk), .rst_b(rst_b), .link(lnk), .addrMode4(mode4),
    .arrayBusy(arrayBusy), .rdData(rdData), .rdAddr(rdAddr), .rdStrobe(rdStrobe),
    .rejected(rejected));
  mfr_link_props u_mfr_link_props (.clk(clk), .rst_b(rst_b), .csB(lnk.csB), .sck(lnk.sck),
    .hostOe(lnk.hostOe), .devOut(lnk.devOut), .devOe(lnk.devOe));

  always #2 clk = ~clk;

  // wire monitor: where in the frame the device turns its lanes around
  always @(posedge clk) begin
    sckQ <= lnk.sck;
    if (rejected) begin
      rejCnt <= rejCnt + 1;
    end
    if (rdStrobe) begin
      strobeCnt <= strobeCnt + 1;
    end
    if (lnk.csB) begin
      rises    <= 6'h00;
      dataRise <= 6'h00;
      dataOe   <= 4'h0;
    end else begin
      if (lnk.sck && !sckQ) begin
        rises <= rises + 6'h01;
      end
      if (lnk.devOe != 4'h0 && dataOe == 4'h0) begin
        dataRise <= rises;
        dataOe   <= lnk.devOe;
      end
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one whole read: four bytes, then chip select up in mid-stream
  task automatic do_read(input logic [7:0] op, input logic [31:0] a, input logic m4,
                         input logic w, input logic bz, input logic [5:0] pre,
                         input logic [3:0] lanes);
    int t;
    int r0;
    int s0;
    logic quiet;
    r0 = rejCnt;
    s0 = strobeCnt;
    quiet = bz || (lanes == 4'h0);
    @(negedge clk);
    opcode    = op;
    addr      = a;
    mode4     = m4;
    wpHold    = w;
    arrayBusy = bz;
    start     = 1'b1;
    @(negedge clk);
    start = 1'b0;
    check("held lines", {28'h0, lnk.hostOe[3:2], lnk.hostOut[3:2]}, {28'h0, {4{w}}});
    for (int k = 0; k < 4; k++) begin
      t = 0;
      do begin
        @(negedge clk);
        t++;
      end while (rxValid !== 1'b1 && t < 3000);
      check("rxValid", {31'h0, rxValid}, 32'h1);
      check("rxData", {24'h0, rxData}, quiet ? 32'hff : {24'h0, dataOf(a + k)});
    end
    check("first data rise", {26'h0, dataRise}, {26'h0, pre});
    check("data lanes", {28'h0, dataOe}, {28'h0, lanes});
    stop = 1'b1;
    @(negedge clk);
    stop = 1'b0;
    t = 0;
    while (busy !== 1'b0 && t < 100) begin
      @(negedge clk);
      t++;
    end
    repeat (8) @(negedge clk);
    check("devOe after stop", {28'h0, lnk.devOe}, 32'h0);
    check("refusals", rejCnt - r0, bz ? 32'h1 : 32'h0);
    check("bytes taken", strobeCnt - s0, quiet ? 32'h0 : 32'h4);
    check("rdAddr", rdAddr, quiet ? 32'h0 : a + 32'h4);
    arrayBusy = 1'b0;
  endtask

  // watchdog: eleven frames take well under 60000 cycles
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    print_verdict();
  end

  initial begin
    clk       = 1'b0;
    rst_b     = 1'b0;
    start     = 1'b0;
    opcode    = 8'h00;
    addr      = 32'h0;
    mode4     = 1'b0;
    stop      = 1'b0;
    wpHold    = 1'b0;
    arrayBusy = 1'b0;
    errors    = 0;
    checks    = 0;
    rejCnt    = 0;
    strobeCnt = 0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    do_read(mfr_pkg::OP_DUAL_OUT4, 32'h8123_4567, 1'b0, 1'b0, 1'b0, 6'd48, 4'h3);
    do_read(mfr_pkg::OP_DUAL_IO,   32'h0012_3456, 1'b0, 1'b0, 1'b0, 6'd24, 4'h3);
    do_read(mfr_pkg::OP_DUAL_IO,   32'h89ab_cdef, 1'b1, 1'b0, 1'b0, 6'd28, 4'h3);
    do_read(mfr_pkg::OP_DUAL_IO4,  32'hfe01_0203, 1'b0, 1'b0, 1'b0, 6'd28, 4'h3);
    do_read(mfr_pkg::OP_QUAD_OUT,  32'h00ab_cdef, 1'b0, 1'b1, 1'b0, 6'd40, 4'hf);
    do_read(mfr_pkg::OP_QUAD_OUT,  32'h0123_4567, 1'b1, 1'b0, 1'b0, 6'd48, 4'hf);
    do_read(mfr_pkg::OP_QUAD_OUT4, 32'h7777_0001, 1'b0, 1'b0, 1'b0, 6'd48, 4'hf);
    do_read(mfr_pkg::OP_QUAD_IO,   32'hffff_fffe, 1'b1, 1'b0, 1'b0, 6'd22, 4'hf);
    do_read(mfr_pkg::OP_QUAD_IO,   32'h0000_0010, 1'b0, 1'b0, 1'b0, 6'd20, 4'hf);
    do_read(8'h03,                 32'h0000_0010, 1'b0, 1'b0, 1'b0, 6'd0, 4'h0);
    do_read(mfr_pkg::OP_QUAD_IO,   32'h0000_0010, 1'b0, 1'b0, 1'b1, 6'd0, 4'h0);
    print_verdict();
  end
endmodule // multi_io_fast_read_front_end_tb_top
